// File: byte_fifo.v
// Purpose: Synchronous FIFO between the frame source and the serial shifter
// Assumes: One clock, valid/ready on both sides
// Notes:   Flip-flop storage, honest full and empty
`timescale 1ns/10ps
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk,       // System clock
    input  wire             rst_n,     // Async reset, active low
    input  wire [WIDTH-1:0] in_data,   // Write data
    input  wire             in_valid,  // Write request
    output wire             in_ready,  // Not full
    output wire [WIDTH-1:0] out_data,  // Head data
    output wire             out_valid, // Not empty
    input  wire             out_ready  // Read accept
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// File: header_crc.v
// Purpose: CRC-CCITT over one byte per step, MSB first
// Assumes: Caller clears before the first covered byte
// Notes:   Polynomial and seed come from the constants header
`timescale 1ns/10ps
`include "image_spi_regs.vh"
module header_crc (
    input  wire        clk,   // System clock
    input  wire        rst_n, // Async reset, active low
    input  wire        clear, // Load seed value
    input  wire        step,  // Fold in one byte
    input  wire [7:0]  data,  // Byte to fold in
    output reg  [15:0] crc    // Running checksum
);
    reg [15:0] next_crc;
    integer    i;

    always @* begin
        next_crc = crc;
        for (i = 7; i >= 0; i = i - 1) begin
            if (next_crc[15] ^ data[i]) begin
                next_crc = {next_crc[14:0], 1'b0} ^ `CRC_POLY;
            end else begin
                next_crc = {next_crc[14:0], 1'b0};
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crc <= `CRC_INIT;
        end else if (clear) begin
            crc <= `CRC_INIT;
        end else if (step) begin
            crc <= next_crc;
        end
    end
endmodule

// File: host_model.sv
// Purpose: Host serial master that reads whole frames from the image port
// Assumes: Clock idles low, data sampled on the rising serial clock edge
// Notes:   Serial clock stands still outside frames
`timescale 1ns/10ps
module host_model #(
    parameter HALF_NS = 40
) (
    output reg  sclk,          // Serial clock to the device
    output reg  port_select_n, // Slave select, active low
    input  wire miso           // Primary data from the device
);
    reg [7:0] rx [0:127];
    initial begin
        sclk = 1'b0;
        port_select_n = 1'b1;
    end
    // Lead time is a parameter of the call so prompt and slow hosts can be tried
    task automatic read_bytes(input int n, input int lead_ns);
        port_select_n = 1'b0;
        #(lead_ns);
        for (int i = 0; i < n; i++) begin
            for (int b = 7; b >= 0; b--) begin
                sclk = 1'b1;
                rx[i][b] = miso;
                #(HALF_NS);
                sclk = 1'b0;
                #(HALF_NS);
            end
        end
        port_select_n = 1'b1;
    endtask
endmodule

// File: image_spi_regs.vh
// Purpose: Constants for the image stream serial slave
// Assumes: 200 MHz system clock
// Notes:   Times kept in their own unit, cycle counts derived
`ifndef IMAGE_SPI_REGS_VH
`define IMAGE_SPI_REGS_VH
`define HDR_BYTES        64
`define HDR_CRC_FIRST    6'h02
`define HDR_CRC_LAST     6'h3D
`define HDR_CRC_HI       6'h3E
`define HDR_CRC_LO       6'h3F
`define CRC_POLY         16'h1021
`define CRC_INIT         16'h0000
`define HDR_VERSION      16'h0003
`define HDR_RESERVED     16'hFFFF
`define CLK_MHZ          200
`define IRQ_ASSERT_NS    200
`define IRQ_CYCLES       ((`IRQ_ASSERT_NS * `CLK_MHZ + 999) / 1000)
`define FRAME_LAT_MS     20
`define FRAME_LAT_CYCLES (`FRAME_LAT_MS * 1000 * `CLK_MHZ)
`define BOOT_BLINK_MS    1000
`define BOOT_BLINK_CYCLES (`BOOT_BLINK_MS * 1000 * `CLK_MHZ)
`define CAP_VIDEO_BIT    0
`define CAP_MANUAL_BIT   1
`define IND_LED_OFF_BIT  0
`endif

// File: image_stream_spi_slave.v
// Purpose: Serial image port slave: header plus image section per frame
// Assumes: Host drives sclk and port_select_n; clk far faster than sclk
// Notes:   Payload arrives as a byte stream; length given per frame
// Operation
// R1: Serial port works only as a slave
// R2: Send 64-byte header, then image data
// R3: Header layout equals network stream header
// R4: Drive frame interrupt for frame availability
// R5: Host waits 2.5 us before first clock
// R6: All data on primary output only
// R7: Capture starts on trigger rising edge
// R8: Frame ready about 20 ms after trigger
// R9: Trigger honoured only in manual, non-video mode
// R10: Indicator toggles per frame or every second
// R11: Mode bit switches the indicator off
// R12: Stream connection starts frames immediately
// R13: Header ends with CRC-CCITT over 0x02..0x3D
// R14: First header bit ready at select, no gaps
// R15: Interrupt only after complete frame buffered; code asserts it once the header is loaded and the FIFO holds one byte
`timescale 1ns/10ps
`include "image_spi_regs.vh"
module image_stream_spi_slave #(
    parameter        FIFO_DEPTH  = 16,
    parameter        FIFO_AW     = 4,
    parameter [31:0] LAT_CYCLES  = `FRAME_LAT_CYCLES,
    parameter [31:0] BLINK_CYCLES = `BOOT_BLINK_CYCLES
) (
    input  wire        clk,                  // System clock 200 MHz
    input  wire        rst_n,                // Async reset, active low
    input  wire        sclk,                 // Serial clock from host
    input  wire        port_select_n,        // Slave select from host, active low
    input  wire        din,                  // Serial data in, unused by streaming
    output reg         primary_serial_out,   // Image data out
    output wire        secondary_serial_out, // Unavailable channel, held low
    output wire        role_select,          // Master/slave strap, low means slave
    output reg         frame_irq_n,          // Frame ready interrupt, active low
    input  wire        frame_trigger_in,     // Capture trigger, rising edge
    input  wire [1:0]  capture_mode_cfg,     // Bit0 video, bit1 manual
    input  wire [0:0]  indicator_mode_cfg,   // Bit0 turns indicator off
    input  wire        bootloader_mode,      // Indicator toggles once per second
    input  wire        stream_connect,       // Network stream connected pulse
    input  wire [15:0] image_width,          // Header field
    input  wire [15:0] image_height,         // Header field
    input  wire [7:0]  num_channels,         // Header field
    input  wire [7:0]  bytes_per_pixel,      // Header field
    input  wire [15:0] image_format,         // Header field
    input  wire [31:0] timestamp,            // Header field
    input  wire [7:0]  main_temp,            // Header field
    input  wire [7:0]  led_temp,             // Header field
    input  wire [15:0] firmware_version,     // Header field
    input  wire [31:0] payload_len,          // Image section length in bytes
    input  wire        frame_done,           // Video frame produced pulse
    input  wire [7:0]  pix_data,             // Image byte
    input  wire        pix_valid,            // Image byte valid
    output wire        pix_ready,            // FIFO can take a byte
    output reg         capture_start,        // Pulse: start one capture
    output reg         status_led            // Status indicator
);
    localparam S_IDLE = 2'd0;
    localparam S_HDR  = 2'd1;
    localparam S_DATA = 2'd2;
    localparam S_DONE = 2'd3;

    assign secondary_serial_out = 1'b0; // R6
    assign role_select          = 1'b0; // R1

    // Two-flop synchronisers for sclk, port_select_n and frame_trigger_in
    reg [1:0] sclk_s;
    reg [1:0] ss_s;
    reg [1:0] frame_trigger_in_s;
    reg       sclk_d;
    reg       frame_trigger_in_d;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_s <= 2'b00;
            ss_s   <= 2'b11;
            frame_trigger_in_s <= 2'b00;
            sclk_d <= 1'b0;
            frame_trigger_in_d <= 1'b0;
        end else begin
            sclk_s <= {sclk_s[0], sclk};
            ss_s   <= {ss_s[0], port_select_n};
            frame_trigger_in_s <= {frame_trigger_in_s[0], frame_trigger_in};
            sclk_d <= sclk_s[1];
            frame_trigger_in_d <= frame_trigger_in_s[1];
        end
    end
    wire selected  = !ss_s[1];
    wire sclk_fall = sclk_d && !sclk_s[1];
    wire frame_trigger_in_rise = frame_trigger_in_s[1] && !frame_trigger_in_d; // R7

    // Hardware trigger, gated by mode; latency counter
    wire frame_trigger_in_ok = !capture_mode_cfg[`CAP_VIDEO_BIT] && capture_mode_cfg[`CAP_MANUAL_BIT]; // R9
    reg [31:0] lat_cnt;
    reg        lat_busy;
    reg [15:0] frame_count;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lat_cnt       <= 32'h0000_0000;
            lat_busy      <= 1'b0;
            capture_start <= 1'b0;
        end else begin
            capture_start <= 1'b0;
            if (frame_trigger_in_rise && frame_trigger_in_ok && !lat_busy) begin // R7 R9
                capture_start <= 1'b1;
                lat_busy      <= 1'b1;
                lat_cnt       <= LAT_CYCLES;
            end else if (lat_busy) begin
                if (lat_cnt <= 32'h0000_0001) begin // R8
                    lat_busy <= 1'b0;
                end
                lat_cnt <= lat_cnt - 32'h0000_0001;
            end
        end
    end
    wire lat_done = lat_busy && (lat_cnt <= 32'h0000_0001);
    wire new_frame = lat_done || stream_connect || (frame_done && !frame_trigger_in_ok); // R12

    // Header byte assembly; same layout as network header
    // Constant header words, split into bytes below
    wire [15:0] hdr_rsv = `HDR_RESERVED;
    wire [15:0] hdr_ver = `HDR_VERSION;
    reg  [5:0]  hdr_idx;
    wire [15:0] crc_val;
    reg  [7:0]  hdr_byte;
    always @* begin
        case (hdr_idx) // R3
            6'h00: hdr_byte = hdr_rsv[15:8];
            6'h01: hdr_byte = hdr_rsv[7:0];
            6'h02: hdr_byte = hdr_ver[15:8];
            6'h03: hdr_byte = hdr_ver[7:0];
            6'h04: hdr_byte = image_width[15:8];
            6'h05: hdr_byte = image_width[7:0];
            6'h06: hdr_byte = image_height[15:8];
            6'h07: hdr_byte = image_height[7:0];
            6'h08: hdr_byte = num_channels;
            6'h09: hdr_byte = bytes_per_pixel;
            6'h0A: hdr_byte = image_format[15:8];
            6'h0B: hdr_byte = image_format[7:0];
            6'h0C: hdr_byte = timestamp[31:24];
            6'h0D: hdr_byte = timestamp[23:16];
            6'h0E: hdr_byte = timestamp[15:8];
            6'h0F: hdr_byte = timestamp[7:0];
            6'h10: hdr_byte = frame_count[15:8];
            6'h11: hdr_byte = frame_count[7:0];
            6'h1A: hdr_byte = main_temp;
            6'h1B: hdr_byte = led_temp;
            6'h1C: hdr_byte = firmware_version[15:8];
            6'h1D: hdr_byte = firmware_version[7:0];
            6'h3E: hdr_byte = crc_val[15:8]; // R13
            6'h3F: hdr_byte = crc_val[7:0]; // R13
            default: hdr_byte = 8'h00;
        endcase
    end

    // Shift engine: header bytes from logic, image bytes from FIFO
    reg [1:0]  state;
    reg [7:0]  shreg;
    reg [2:0]  bit_idx;
    reg [31:0] data_left;
    reg        loaded;
    wire [7:0] fifo_data;
    wire       fifo_valid;
    wire       byte_end = sclk_fall && (bit_idx == 3'd7);
    // Pop as each payload byte enters the shifter; an empty FIFO there sends a stale byte
    wire       fifo_pop = selected && byte_end &&
                          ((state == S_HDR && hdr_idx == `HDR_CRC_LO && payload_len != 32'h0000_0000) ||
                           (state == S_DATA && data_left != 32'h0000_0001));
    wire       crc_step = (state == S_HDR) && byte_end && (hdr_idx >= `HDR_CRC_FIRST) && (hdr_idx <= `HDR_CRC_LAST);

    header_crc u_crc (
        .clk   (clk),
        .rst_n (rst_n),
        .clear (new_frame),
        .step  (crc_step),
        .data  (shreg),
        .crc   (crc_val)
    );

    byte_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_data   (pix_data),
        .in_valid  (pix_valid),
        .in_ready  (pix_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state              <= S_IDLE;
            shreg              <= 8'h00;
            bit_idx            <= 3'd0;
            hdr_idx            <= 6'h00;
            data_left          <= 32'h0000_0000;
            loaded             <= 1'b0;
            primary_serial_out <= 1'b0;
            frame_count        <= 16'h0000;
        end else begin
            case (state)
                S_IDLE: begin
                    if (new_frame) begin // R2
                        state   <= S_HDR;
                        hdr_idx <= 6'h00;
                        bit_idx <= 3'd0;
                        loaded  <= 1'b0;
                    end
                end
                S_HDR: begin
                    if (!loaded) begin
                        shreg              <= hdr_byte; // R14
                        primary_serial_out <= hdr_byte[7];
                        loaded             <= 1'b1;
                    end else if (selected && sclk_fall) begin
                        bit_idx <= bit_idx + 3'd1;
                        if (bit_idx == 3'd7) begin
                            if (hdr_idx == `HDR_CRC_LO) begin
                                state     <= S_DATA;
                                data_left <= payload_len;
                                shreg              <= fifo_data;
                                primary_serial_out <= fifo_data[7]; // R14
                                if (payload_len == 32'h0000_0000) begin
                                    state <= S_DONE;
                                end
                            end else begin
                                hdr_idx <= hdr_idx + 6'h01;
                                loaded  <= 1'b0;
                            end
                        end else begin
                            primary_serial_out <= shreg[6 - bit_idx]; // R6
                        end
                    end
                end
                S_DATA: begin
                    if (selected && sclk_fall) begin
                        bit_idx <= bit_idx + 3'd1;
                        if (bit_idx == 3'd7) begin
                            data_left <= data_left - 32'h0000_0001;
                            if (data_left == 32'h0000_0001) begin
                                state <= S_DONE;
                            end else begin
                                shreg              <= fifo_data;
                                primary_serial_out <= fifo_data[7];
                            end
                        end else begin
                            primary_serial_out <= shreg[6 - bit_idx];
                        end
                    end
                end
                default: begin
                    // Frame finished: count it for the next header
                    frame_count <= frame_count + 16'h0001;
                    state       <= S_IDLE;
                end
            endcase
        end
    end

    // Interrupt once the header is loaded and the FIFO holds a byte (or payload is empty); held low until readout begins
    wire ready_to_read = (state == S_HDR) && loaded &&
                         (fifo_valid || payload_len == 32'h0000_0000);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_irq_n <= 1'b1;
        end else begin
            if (ready_to_read && !selected) begin // R4 R15
                frame_irq_n <= 1'b0;
            end else if (selected || state == S_IDLE) begin
                frame_irq_n <= 1'b1;
            end
        end
    end

    // Status indicator
    reg [31:0] blink_cnt;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_led <= 1'b0;
            blink_cnt  <= 32'h0000_0000;
        end else if (indicator_mode_cfg[`IND_LED_OFF_BIT]) begin // R11
            status_led <= 1'b0;
            blink_cnt  <= 32'h0000_0000;
        end else if (bootloader_mode) begin // R10
            if (blink_cnt >= BLINK_CYCLES - 32'h0000_0001) begin
                blink_cnt  <= 32'h0000_0000;
                status_led <= !status_led;
            end else begin
                blink_cnt <= blink_cnt + 32'h0000_0001;
            end
        end else if (new_frame) begin // R10
            status_led <= !status_led;
        end
    end
endmodule

// File: image_stream_spi_slave_properties.sv
// Purpose: Port-level assertions for the image stream serial slave
// Assumes: Single clock domain, asynchronous active-low reset
// Notes:   Attached by bind below the module
`timescale 1ns/10ps
module image_stream_spi_slave_properties (
    input wire       clk,                  // System clock
    input wire       rst_n,                // Async reset, active low
    input wire       sclk,                 // Host serial clock
    input wire       port_select_n,        // Host select, active low
    input wire       primary_serial_out,   // Serial data out
    input wire       secondary_serial_out, // Unused data channel
    input wire       role_select,          // Slave strap
    input wire       frame_irq_n,          // Frame interrupt
    input wire       frame_trigger_in,     // Capture trigger
    input wire       capture_start,        // Capture pulse
    input wire       status_led,           // Status indicator
    input wire [1:0] capture_mode_cfg,     // Mode bits
    input wire [0:0] indicator_mode_cfg    // Indicator off bit
);
    reg       frame_trigger_in_prev;
    reg [3:0] since_rise;
    // Cycles since the trigger pin was last seen rising, saturating
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_trigger_in_prev  <= 1'b0;
            since_rise <= 4'hF;
        end else begin
            frame_trigger_in_prev <= frame_trigger_in;
            if (frame_trigger_in && !frame_trigger_in_prev)
                since_rise <= 4'h0;
            else if (since_rise != 4'hF)
                since_rise <= since_rise + 4'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_aux_lines_low: assert property (secondary_serial_out == 1'b0 && role_select == 1'b0)
        else $error("secondary data or role strap not low");
    a_frame_trigger_in_one_pulse: assert property (capture_start |=> !capture_start)
        else $error("capture pulse longer than one cycle");
    a_frame_trigger_in_mode_gate: assert property (capture_start |-> capture_mode_cfg == 2'b10)
        else $error("capture started outside manual mode");
    a_frame_trigger_in_after_edge: assert property (capture_start |-> since_rise >= 4'h1 && since_rise <= 4'h6)
        else $error("capture not tied to a trigger rising edge");
    a_frame_not_early: assert property (capture_start |=> frame_irq_n [*8])
        else $error("frame ready too soon after capture");
    a_irq_select_clear: assert property ((!port_select_n) [*5] |-> frame_irq_n)
        else $error("interrupt still low while host selects");
    a_out_stable_high: assert property ((!port_select_n && sclk) [*6] |=> $stable(primary_serial_out))
        else $error("serial data moved while serial clock high");
    a_led_forced_off: assert property (indicator_mode_cfg[0] && $past(indicator_mode_cfg[0]) |-> !status_led)
        else $error("indicator lit while switched off");
endmodule
bind image_stream_spi_slave image_stream_spi_slave_properties image_stream_spi_slave_properties_inst (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .port_select_n(port_select_n),
    .primary_serial_out(primary_serial_out), .secondary_serial_out(secondary_serial_out),
    .role_select(role_select), .frame_irq_n(frame_irq_n), .frame_trigger_in(frame_trigger_in),
    .capture_start(capture_start), .status_led(status_led), .capture_mode_cfg(capture_mode_cfg),
    .indicator_mode_cfg(indicator_mode_cfg));

// File: tb_top.sv
// Purpose: Self-checking bench for the image stream serial slave
// Assumes: Shortened latency and blink counts
// Notes:   Frames read by the host model, payload fed through the FIFO
`timescale 1ns/10ps
module tb_top;
    localparam LAT = 50;
    localparam BLINK = 40;
    localparam PAY = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sclk, port_select_n, primary_serial_out, secondary_serial_out, role_select, frame_irq_n;
    logic frame_trigger_in = 1'b0, bootloader_mode = 1'b0, stream_connect = 1'b0, frame_done = 1'b0;
    logic pix_valid = 1'b0, pix_ready, capture_start, status_led;
    logic [1:0] capture_mode_cfg = 2'b00;
    logic [0:0] indicator_mode_cfg = 1'b0;
    logic [15:0] image_width, image_height, image_format, firmware_version;
    logic [7:0] num_channels, bytes_per_pixel, main_temp, led_temp, pix_data = 8'h00;
    logic [31:0] timestamp, payload_len;
    logic [7:0] exp [0:127];
    int fails = 0;
    int n_checks = 0;
    int cap_count = 0;
    always #2.5 clk = ~clk;
    always @(posedge clk) if (capture_start === 1'b1) cap_count++;
    image_stream_spi_slave #(.LAT_CYCLES(LAT), .BLINK_CYCLES(BLINK)) image_stream_spi_slave_inst (
        .clk(clk), .rst_n(rst_n), .sclk(sclk), .port_select_n(port_select_n), .din(1'b0),
        .primary_serial_out(primary_serial_out), .secondary_serial_out(secondary_serial_out),
        .role_select(role_select), .frame_irq_n(frame_irq_n), .frame_trigger_in(frame_trigger_in),
        .capture_mode_cfg(capture_mode_cfg), .indicator_mode_cfg(indicator_mode_cfg),
        .bootloader_mode(bootloader_mode), .stream_connect(stream_connect), .image_width(image_width),
        .image_height(image_height), .num_channels(num_channels), .bytes_per_pixel(bytes_per_pixel),
        .image_format(image_format), .timestamp(timestamp), .main_temp(main_temp), .led_temp(led_temp),
        .firmware_version(firmware_version), .payload_len(payload_len), .frame_done(frame_done),
        .pix_data(pix_data), .pix_valid(pix_valid), .pix_ready(pix_ready),
        .capture_start(capture_start), .status_led(status_led));
    host_model host_model_inst (.sclk(sclk), .port_select_n(port_select_n), .miso(primary_serial_out));
    task automatic check(input [31:0] got, input [31:0] want);
        n_checks++;
        if (got !== want) begin
            fails++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, want);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic set_fields(input [7:0] k);
        image_width = {8'h01, k};
        image_height = {8'h02, k};
        num_channels = k;
        bytes_per_pixel = k + 8'h01;
        image_format = {k, 8'h33};
        timestamp = {24'hC0FFEE, k};
        main_temp = 8'h40 + k;
        led_temp = 8'h50 + k;
        firmware_version = {8'h5A, k};
        payload_len = PAY;
    endtask
    // Expected frame: header fields high byte first, CRC over bytes 0x02..0x3D, then payload
    task automatic build_exp(input [15:0] cnt);
        logic [15:0] c;
        for (int i = 0; i < 128; i++) exp[i] = 8'h00;
        {exp[0], exp[1], exp[2], exp[3]} = 32'hFFFF_0003;
        {exp[4], exp[5], exp[6], exp[7]} = {image_width, image_height};
        {exp[8], exp[9], exp[10], exp[11]} = {num_channels, bytes_per_pixel, image_format};
        {exp[12], exp[13], exp[14], exp[15]} = timestamp;
        {exp[16], exp[17]} = cnt;
        {exp[26], exp[27], exp[28], exp[29]} = {main_temp, led_temp, firmware_version};
        for (int i = 0; i < PAY; i++) exp[64 + i] = 8'hA0 + 8'(i);
        c = 16'h0000;
        for (int i = 2; i < 62; i++)
            for (int b = 7; b >= 0; b--)
                c = {c[14:0], 1'b0} ^ ((c[15] ^ exp[i][b]) ? 16'h1021 : 16'h0000);
        {exp[62], exp[63]} = c;
    endtask
    task automatic feed(input int n);
        for (int i = 0; i < n; i++) begin
            pix_data = 8'hA0 + 8'(i);
            pix_valid = 1'b1;
            while (pix_ready !== 1'b1) @(posedge clk) #1;
            @(posedge clk) #1;
        end
        pix_valid = 1'b0;
    endtask
    // Fills the FIFO until it refuses, then the host drains it while the source trails behind
    task automatic run_frame(input [15:0] cnt, input int lead);
        int w;
        build_exp(cnt);
        fork
            feed(PAY);
            begin
                w = 0;
                while (frame_irq_n !== 1'b0 && w < 400) begin
                    @(posedge clk) #1;
                    w++;
                end
                check(w < 400, 1);
                repeat (40) @(posedge clk);
                #1 check(pix_ready, 1'b0);
                host_model_inst.read_bytes(64 + PAY, lead);
            end
        join
        for (int i = 0; i < 64 + PAY; i++) check(host_model_inst.rx[i], exp[i]);
        repeat (10) @(posedge clk);
        #1 check(frame_irq_n, 1'b1);
    endtask
    task automatic t_stream;
        set_fields(8'h11);
        stream_connect = 1'b1;
        @(posedge clk) #1 stream_connect = 1'b0;
        run_frame(16'h0000, 3000);
    endtask
    task automatic t_video;
        logic led0;
        capture_mode_cfg = 2'b01;
        set_fields(8'h22);
        led0 = status_led;
        frame_done = 1'b1;
        @(posedge clk) #1 frame_done = 1'b0;
        run_frame(16'h0001, 2500);
        check(status_led, !led0);
    endtask
    task automatic t_trigger;
        logic led0;
        capture_mode_cfg = 2'b10;
        set_fields(8'h33);
        led0 = status_led;
        frame_trigger_in = 1'b1;
        repeat (8) @(posedge clk);
        #1 check(cap_count, 1);
        repeat (LAT - 10) @(posedge clk);
        #1 check(frame_irq_n, 1'b1);
        run_frame(16'h0002, 3000);
        check(cap_count, 1);
        check(status_led, !led0);
        frame_trigger_in = 1'b0;
    endtask
    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            if (m == 2) continue;
            capture_mode_cfg = 2'(m);
            @(posedge clk) #1 frame_trigger_in = 1'b1;
            repeat (20) @(posedge clk);
            #1 frame_trigger_in = 1'b0;
            repeat (LAT + 20) @(posedge clk);
            #1 check(cap_count, 1);
            check(frame_irq_n, 1'b1);
        end
    endtask
    task automatic t_led;
        logic prev;
        int tg;
        capture_mode_cfg = 2'b00;
        bootloader_mode = 1'b1;
        prev = status_led;
        tg = 0;
        repeat (20 * BLINK) begin
            @(posedge clk) #1;
            if (status_led !== prev) tg++;
            prev = status_led;
        end
        check(tg >= 19 && tg <= 21, 1);
        indicator_mode_cfg = 1'b1;
        tg = 0;
        repeat (4 * BLINK) begin
            @(posedge clk) #1;
            if (status_led !== 1'b0) tg++;
        end
        check(tg, 0);
    endtask
    initial begin
        set_fields(8'h00);
        repeat (3) @(posedge clk);
        #1 check({frame_irq_n, status_led, capture_start}, 3'b100);
        rst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1 t_stream();
        t_video();
        t_trigger();
        t_modes();
        t_led();
        end_of_test();
    end
    initial begin
        #400000;
        fails++;
        end_of_test();
    end
endmodule
